// file: design/fpec_pkg.sv
package fpec_pkg;

  // ----------------------------------------------------------------
  // apb map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 19;
  localparam logic [18:0] REG_CTRL = 19'h00000;
  localparam logic [18:0] REG_STAT = 19'h00004;
  // paddr bit that selects the array window; array byte N sits at word N
  localparam int ARR_SEL_BIT = 18;
  localparam int FA_LSB = 2;
  localparam int FA_MSB = 17;

  // ----------------------------------------------------------------
  // nv_array_control fields
  // ----------------------------------------------------------------
  localparam int PGM_BIT = 0;
  localparam int ERASE_BIT = 1;
  localparam int MASS_BIT = 2;
  localparam int HV_BIT = 3;
  localparam logic [7:0] CTRL_RST = 8'h00;

  // ----------------------------------------------------------------
  // status fields
  // ----------------------------------------------------------------
  localparam int ST_REFUSED_BIT = 0;
  localparam int ST_ERASING_BIT = 1;
  localparam int ST_PROT_ALL_BIT = 2;
  localparam int ST_SEQ_LSB = 4;

  // ----------------------------------------------------------------
  // array geometry
  // ----------------------------------------------------------------
  localparam logic [15:0] ARRAY_LO = 16'hee00;
  localparam int ARRAY_BYTES = 4608;
  localparam int ARRAY_AW = 13;
  localparam int PAGE_LSB = 6;
  localparam int ROW_LSB = 5;
  localparam logic [5:0] PAGE_LAST = 6'h3f;
  localparam logic [15:0] PROT_ADDR = 16'hffbe;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  localparam logic [7:0] PROT_NONE = 8'hff;
  localparam logic [1:0] PROT_TOP_BITS = 2'h3;
  localparam logic [5:0] PROT_LOW_BITS = 6'h00;

  // ----------------------------------------------------------------
  // sequence states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    FPEC_IDLE,
    FPEC_SELECTED,
    FPEC_PROT_READ,
    FPEC_ARMED,
    FPEC_HIGH_V
  } fpec_seq_e;

  // protect start address from the eight protect bits
  function automatic logic [15:0] fpec_prot_start(input logic [7:0] bits);
    return {PROT_TOP_BITS, bits, PROT_LOW_BITS};
  endfunction : fpec_prot_start

endpackage : fpec_pkg

// file: design/fpec_array.sv
module fpec_array #(
  parameter int DEPTH = fpec_pkg::ARRAY_BYTES,
  parameter int AW = fpec_pkg::ARRAY_AW
) (
  // clock
  input wire logic ref_clk_i,
  // read port
  input wire logic [AW-1:0] rd_idx_i,
  output logic [7:0] rd_data_o,
  // program port, can only pull bits to zero
  input wire logic prog_en_i,
  input wire logic [AW-1:0] prog_idx_i,
  input wire logic [7:0] prog_data_i,
  // erase port, one byte per cycle
  input wire logic clr_en_i,
  input wire logic [AW-1:0] clr_idx_i,
  // protect byte, always visible
  output logic [7:0] prot_o
);

  logic [7:0] mem [DEPTH];
  localparam logic [AW-1:0] PROT_IDX = AW'(fpec_pkg::PROT_ADDR - fpec_pkg::ARRAY_LO);

  // nonvolatile: no reset, delivered erased
  initial begin
    for (int i = 0; i < DEPTH; i++) begin
      mem[i] = fpec_pkg::ERASED_BYTE;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (clr_en_i) begin
      mem[clr_idx_i] <= fpec_pkg::ERASED_BYTE;
    end
    if (prog_en_i) begin
      mem[prog_idx_i] <= mem[prog_idx_i] & prog_data_i;
    end
  end

  assign rd_data_o = mem[rd_idx_i];
  assign prot_o = mem[PROT_IDX];

endmodule : fpec_array

// file: design/fpec_protect.sv
module fpec_protect (
  // protect setting and target
  input wire logic [7:0] prot_bits_i,
  input wire logic [15:0] target_i,
  input wire logic mass_i,
  // override
  input wire logic test_voltage_i,
  // result
  output logic blocked_o,
  output logic prot_all_o
);

  logic [15:0] start;
  logic any_prot;

  always_comb begin
    start = fpec_pkg::fpec_prot_start(prot_bits_i);
    any_prot = prot_bits_i != fpec_pkg::PROT_NONE;
    prot_all_o = any_prot && start <= fpec_pkg::ARRAY_LO;
    if (test_voltage_i) begin
      blocked_o = 1'b0;
    end else if (mass_i) begin
      blocked_o = any_prot;
    end else begin
      blocked_o = any_prot && target_i >= start;
    end
  end

endmodule : fpec_protect

// file: design/fpec_top.sv
module fpec_top #(
  parameter int DEPTH = fpec_pkg::ARRAY_BYTES,
  parameter int AW = fpec_pkg::ARRAY_AW
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [fpec_pkg::ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // device pins
  input wire logic test_voltage_i,
  input wire logic halt_i,
  // array control
  output logic pump_on_o,
  output logic array_hv_o,
  output logic standby_o
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic program_select, next_program_select;
  logic erase_select, next_erase_select;
  logic whole_array_select, next_whole_array_select;
  logic high_voltage_on, next_high_voltage_on;
  logic hv_refused, next_hv_refused;
  fpec_pkg::fpec_seq_e seq, next_seq;
  logic [15:0] latch_addr, next_latch_addr;
  logic erasing, next_erasing;
  logic [AW-1:0] er_idx, next_er_idx;
  logic [AW-1:0] er_last, next_er_last;
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;
  logic next_pump_on;
  logic next_standby;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  logic access, wr_fire, rd_fire;
  logic arr_sel, arr_hit, ctrl_hit, stat_hit;
  logic [15:0] fl_addr;
  logic [AW-1:0] fl_idx;
  logic [7:0] arr_rd, prot_bits;
  logic blocked, prot_all;
  logic [7:0] wbyte;
  logic prog_en, clr_en;
  logic row_match;

  assign access = psel_i && penable_i;
  assign wr_fire = access && pready_o && pwrite_i;
  assign rd_fire = access && pready_o && !pwrite_i;
  assign arr_sel = paddr_i[fpec_pkg::ARR_SEL_BIT];
  assign fl_addr = paddr_i[fpec_pkg::FA_MSB:fpec_pkg::FA_LSB];
  assign arr_hit = arr_sel && fl_addr >= fpec_pkg::ARRAY_LO;
  assign fl_idx = AW'(fl_addr - fpec_pkg::ARRAY_LO);
  assign ctrl_hit = !arr_sel && paddr_i == fpec_pkg::REG_CTRL;
  assign stat_hit = !arr_sel && paddr_i == fpec_pkg::REG_STAT;
  assign wbyte = pwdata_i[7:0];

  // ----------------------------------------------------------------
  // array and protection
  // ----------------------------------------------------------------
  fpec_array #(
    .DEPTH(DEPTH),
    .AW(AW)
  ) u_array (
    .ref_clk_i(ref_clk_i),
    .rd_idx_i(fl_idx),
    .rd_data_o(arr_rd),
    .prog_en_i(prog_en),
    .prog_idx_i(fl_idx),
    .prog_data_i(wbyte),
    .clr_en_i(clr_en),
    .clr_idx_i(er_idx),
    .prot_o(prot_bits)
  );

  // the latched target is checked, so a stray address cannot dodge it
  fpec_protect u_protect (
    .prot_bits_i(prot_bits),
    .target_i(latch_addr),
    .mass_i(whole_array_select),
    .test_voltage_i(test_voltage_i),
    .blocked_o(blocked),
    .prot_all_o(prot_all)
  );

  // ----------------------------------------------------------------
  // program and erase strobes
  // ----------------------------------------------------------------
  always_comb begin
    row_match = fl_addr[15:fpec_pkg::ROW_LSB] == latch_addr[15:fpec_pkg::ROW_LSB];
    // only writes inside the latched row count; others are dropped
    prog_en = wr_fire && arr_hit && seq == fpec_pkg::FPEC_HIGH_V && high_voltage_on
              && program_select && row_match && !blocked;
    clr_en = erasing && high_voltage_on && erase_select;
  end

  // ----------------------------------------------------------------
  // control register and sequence
  // ----------------------------------------------------------------
  logic want_pgm, want_erase, hv_ok, sel_any;

  always_comb begin
    next_program_select = program_select;
    next_erase_select = erase_select;
    next_whole_array_select = whole_array_select;
    next_high_voltage_on = high_voltage_on;
    next_hv_refused = hv_refused;
    next_seq = seq;
    next_latch_addr = latch_addr;
    want_pgm = wbyte[fpec_pkg::PGM_BIT];
    want_erase = wbyte[fpec_pkg::ERASE_BIT];
    hv_ok = 1'b0;
    if (wr_fire && ctrl_hit) begin
      // a write asking for both selects leaves both untouched
      if (!(want_pgm && want_erase)) begin
        next_program_select = want_pgm;
        next_erase_select = want_erase;
      end
      next_whole_array_select = wbyte[fpec_pkg::MASS_BIT];
      if (!wbyte[fpec_pkg::HV_BIT]) begin
        next_high_voltage_on = 1'b0;
      end else if (!high_voltage_on) begin
        hv_ok = seq == fpec_pkg::FPEC_ARMED && !blocked
                && (next_program_select || next_erase_select);
        next_high_voltage_on = hv_ok;
        if (!hv_ok) begin
          next_hv_refused = 1'b1;
        end
      end
    end
    // sticky refusal: software clears with a one, a new refusal wins
    if (wr_fire && stat_hit && wbyte[fpec_pkg::ST_REFUSED_BIT] && !(hv_ok == 1'b0
        && wr_fire && ctrl_hit)) begin
      next_hv_refused = 1'b0;
    end
    sel_any = next_program_select || next_erase_select;
    unique case (seq)
      fpec_pkg::FPEC_IDLE: begin
        if (sel_any) begin
          next_seq = fpec_pkg::FPEC_SELECTED;
        end
      end
      fpec_pkg::FPEC_SELECTED: begin
        if (!sel_any) begin
          next_seq = fpec_pkg::FPEC_IDLE;
        end else if (rd_fire && arr_sel && fl_addr == fpec_pkg::PROT_ADDR) begin
          next_seq = fpec_pkg::FPEC_PROT_READ;
        end
      end
      fpec_pkg::FPEC_PROT_READ: begin
        if (!sel_any) begin
          next_seq = fpec_pkg::FPEC_IDLE;
        end else if (wr_fire && arr_hit) begin
          next_seq = fpec_pkg::FPEC_ARMED;
          next_latch_addr = fl_addr;
        end
      end
      fpec_pkg::FPEC_ARMED: begin
        if (!sel_any) begin
          next_seq = fpec_pkg::FPEC_IDLE;
        end else if (hv_ok) begin
          next_seq = fpec_pkg::FPEC_HIGH_V;
        end
      end
      fpec_pkg::FPEC_HIGH_V: begin
        if (!next_high_voltage_on) begin
          next_seq = sel_any ? fpec_pkg::FPEC_SELECTED : fpec_pkg::FPEC_IDLE;
        end
      end
    endcase
    // halt drops every control line at once
    if (halt_i) begin
      next_program_select = 1'b0;
      next_erase_select = 1'b0;
      next_whole_array_select = 1'b0;
      next_high_voltage_on = 1'b0;
      next_seq = fpec_pkg::FPEC_IDLE;
    end
  end

  // ----------------------------------------------------------------
  // erase engine
  // ----------------------------------------------------------------
  // one byte per cycle; 4608 cycles is far below any erase time
  logic [AW-1:0] page_base;

  always_comb begin
    next_erasing = erasing;
    next_er_idx = er_idx;
    next_er_last = er_last;
    page_base = AW'({latch_addr[15:fpec_pkg::PAGE_LSB], {fpec_pkg::PAGE_LSB{1'b0}}}
                    - fpec_pkg::ARRAY_LO);
    if (hv_ok && next_erase_select) begin
      next_erasing = 1'b1;
      if (whole_array_select) begin
        next_er_idx = '0;
        next_er_last = AW'(DEPTH - 1);
      end else begin
        next_er_idx = page_base;
        next_er_last = page_base | AW'(fpec_pkg::PAGE_LAST);
      end
    end else if (clr_en) begin
      next_er_idx = er_idx + 1'b1;
      if (er_idx == er_last) begin
        next_erasing = 1'b0;
      end
    end
    if (!next_high_voltage_on || !next_erase_select) begin
      next_erasing = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // apb answer, one wait state so the data comes from a flop
  // ----------------------------------------------------------------
  always_comb begin
    next_pready = access && !pready_o;
    next_prdata = '0;
    next_pslverr = 1'b0;
    if (access && !pready_o) begin
      if (arr_hit) begin
        next_prdata = {24'h000000, arr_rd};
      end else if (ctrl_hit) begin
        next_prdata[fpec_pkg::PGM_BIT] = program_select;
        next_prdata[fpec_pkg::ERASE_BIT] = erase_select;
        next_prdata[fpec_pkg::MASS_BIT] = whole_array_select;
        next_prdata[fpec_pkg::HV_BIT] = high_voltage_on;
      end else if (stat_hit) begin
        next_prdata[fpec_pkg::ST_REFUSED_BIT] = hv_refused;
        next_prdata[fpec_pkg::ST_ERASING_BIT] = erasing;
        next_prdata[fpec_pkg::ST_PROT_ALL_BIT] = prot_all;
        next_prdata[fpec_pkg::ST_SEQ_LSB +: 3] = seq;
      end else begin
        next_pslverr = 1'b1;
      end
    end
    next_pump_on = next_high_voltage_on;
    next_standby = !next_high_voltage_on && !next_program_select
                   && !next_erase_select;
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      program_select <= fpec_pkg::CTRL_RST[fpec_pkg::PGM_BIT];
      erase_select <= fpec_pkg::CTRL_RST[fpec_pkg::ERASE_BIT];
      whole_array_select <= fpec_pkg::CTRL_RST[fpec_pkg::MASS_BIT];
      high_voltage_on <= fpec_pkg::CTRL_RST[fpec_pkg::HV_BIT];
      hv_refused <= 1'b0;
      seq <= fpec_pkg::FPEC_IDLE;
      latch_addr <= '0;
      erasing <= 1'b0;
      er_idx <= '0;
      er_last <= '0;
      prdata_o <= '0;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      pump_on_o <= 1'b0;
      array_hv_o <= 1'b0;
      standby_o <= 1'b1;
    end else begin
      program_select <= next_program_select;
      erase_select <= next_erase_select;
      whole_array_select <= next_whole_array_select;
      high_voltage_on <= next_high_voltage_on;
      hv_refused <= next_hv_refused;
      seq <= next_seq;
      latch_addr <= next_latch_addr;
      erasing <= next_erasing;
      er_idx <= next_er_idx;
      er_last <= next_er_last;
      prdata_o <= next_prdata;
      pready_o <= next_pready;
      pslverr_o <= next_pslverr;
      pump_on_o <= next_pump_on;
      array_hv_o <= next_pump_on;
      standby_o <= next_standby;
    end
  end

endmodule : fpec_top

// file: verif/fpec_checker.sv
module fpec_checker (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  // apb
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [fpec_pkg::ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  // pins
  input wire logic halt_i,
  input wire logic pump_on_o,
  input wire logic array_hv_o,
  input wire logic standby_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rstn_i);

  // ----------------------------------------------------------------
  // bus handshake
  // ----------------------------------------------------------------
  ready_once_a: assert property (pready_o |=> !pready_o)
    else $error("pready held past one cycle");
  ready_wait_a: assert property (psel_i && penable_i && !pready_o |=> pready_o)
    else $error("pready late");
  ready_cause_a: assert property (pready_o |-> $past(psel_i && penable_i))
    else $error("pready without access");
  err_ready_a: assert property (pslverr_o |-> pready_o)
    else $error("pslverr without pready");
  rdata_byte_a: assert property (pready_o |-> prdata_o[31:8] == 24'h0)
    else $error("upper read data not zero");
  unmapped_err_a: assert property (psel_i && penable_i && pready_o && !paddr_i[18]
    && paddr_i[17:3] != 15'h0 |-> pslverr_o)
    else $error("unmapped register not refused");

  // ----------------------------------------------------------------
  // high voltage
  // ----------------------------------------------------------------
  pump_pair_a: assert property (pump_on_o == array_hv_o)
    else $error("pump and array voltage differ");
  pump_standby_a: assert property (pump_on_o |-> !standby_o)
    else $error("standby while pump on");
  halt_stop_a: assert property (halt_i |=> !pump_on_o && standby_o)
    else $error("halt did not stop operation");
  hv_cause_a: assert property ($rose(pump_on_o) |-> $past(pwrite_i && pready_o
    && paddr_i == fpec_pkg::REG_CTRL && pwdata_i[fpec_pkg::HV_BIT]))
    else $error("pump on without control write");
endmodule : fpec_checker

bind fpec_top fpec_checker u_chk (
  .ref_clk_i(ref_clk_i),
  .rstn_i(rstn_i),
  .psel_i(psel_i),
  .penable_i(penable_i),
  .pwrite_i(pwrite_i),
  .paddr_i(paddr_i),
  .pwdata_i(pwdata_i),
  .prdata_o(prdata_o),
  .pready_o(pready_o),
  .pslverr_o(pslverr_o),
  .halt_i(halt_i),
  .pump_on_o(pump_on_o),
  .array_hv_o(array_hv_o),
  .standby_o(standby_o)
);

// file: verif/fpec_cpu.sv
module fpec_cpu (
  // clock
  input wire logic ref_clk_i,
  // apb master
  output logic psel_o,
  output logic penable_o,
  output logic pwrite_o,
  output logic [fpec_pkg::ADDR_W-1:0] paddr_o,
  output logic [31:0] pwdata_o,
  input wire logic [31:0] prdata_i,
  input wire logic pready_i,
  input wire logic pslverr_i
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    psel_o = 1'b0;
    penable_o = 1'b0;
    pwrite_o = 1'b0;
    paddr_o = '0;
    pwdata_o = '0;
  end

  // ----------------------------------------------------------------
  // one transfer; steps come from here, never from array fetches
  // ----------------------------------------------------------------
  task xfer(input logic w, input logic [18:0] a, input logic [7:0] d,
            output logic [7:0] r, output logic e, output logic to);
    int n;
    n = 0;
    @(posedge ref_clk_i);
    psel_o <= 1'b1;
    pwrite_o <= w;
    paddr_o <= a;
    pwdata_o <= {24'h0, d};
    @(posedge ref_clk_i);
    penable_o <= 1'b1;
    @(posedge ref_clk_i);
    while (pready_i !== 1'b1 && n < 20) begin
      @(posedge ref_clk_i);
      n++;
    end
    r = prdata_i[7:0];
    e = pslverr_i;
    to = (n >= 20);
    psel_o <= 1'b0;
    penable_o <= 1'b0;
    // idle bus shows garbage, not the last request
    paddr_o <= ~a;
    pwdata_o <= ~pwdata_o;
  endtask : xfer
endmodule : fpec_cpu

// file: verif/fpec_top_tb.sv
module fpec_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rstn, psel, pen, pwr, prdy, perr, tv, halt, pump, ahv, stby;
  logic [18:0] paddr;
  logic [31:0] pwd, prd;
  logic [7:0] rv;
  logic er, to;
  int n_fail, n_tests;

  fpec_top DUT (.ref_clk_i(clk), .rstn_i(rstn), .psel_i(psel), .penable_i(pen),
    .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwd), .prdata_o(prd), .pready_o(prdy),
    .pslverr_o(perr), .test_voltage_i(tv), .halt_i(halt), .pump_on_o(pump),
    .array_hv_o(ahv), .standby_o(stby));
  fpec_cpu u_cpu (.ref_clk_i(clk), .psel_o(psel), .penable_o(pen), .pwrite_o(pwr),
    .paddr_o(paddr), .pwdata_o(pwd), .prdata_i(prd), .pready_i(prdy), .pslverr_i(perr));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task finish_test;
    $display("compares %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : finish_test
  task chk_d(input logic [7:0] g, input logic [7:0] x);
    n_tests++;
    if (g !== x) begin
      n_fail++;
      $display("Error t=%0t got %h exp %h", $time, g, x);
    end
  endtask : chk_d
  task chk_b(input logic g, input logic x);
    n_tests++;
    if (g !== x) begin
      n_fail++;
      $display("Error t=%0t got %h exp %h", $time, g, x);
    end
  endtask : chk_b
  task acc(input logic w, input logic [18:0] a, input logic [7:0] d);
    u_cpu.xfer(w, a, d, rv, er, to);
    if (to) begin
      n_fail++;
      finish_test();
    end
  endtask : acc
  task wr(input logic [18:0] a, input logic [7:0] d);
    // top array byte doubles as watchdog service; never touched under high voltage
    if (pump && a == ar(16'hffff)) chk_b(1'b1, 1'b0);
    acc(1'b1, a, d);
  endtask : wr
  task rd(input logic [18:0] a);
    acc(1'b0, a, 8'h00);
  endtask : rd
  task wt(input int n);
    repeat (n) @(posedge clk);
  endtask : wt
  function automatic logic [18:0] ar(input logic [15:0] fa);
    return {1'b1, fa, 2'b00};
  endfunction : ar
  task arm(input logic [7:0] sel, input logic [15:0] fa);
    wr(fpec_pkg::REG_CTRL, sel);
    rd(ar(fpec_pkg::PROT_ADDR));
    wr(ar(fa), 8'h00);
    wt(100);
    wr(fpec_pkg::REG_CTRL, sel | 8'h08);
  endtask : arm
  task prog(input logic [15:0] fa, input logic [7:0] d);
    arm(8'h01, fa);
    wt(50);
    chk_b(pump, 1'b1);
    chk_b(ahv, 1'b1);
    wr(ar(fa), d);
    wt(300);
    wr(ar(fa + 16'h0020), 8'h00);
    wt(300);
    wr(fpec_pkg::REG_CTRL, 8'h08);
    wt(50);
    wr(fpec_pkg::REG_CTRL, 8'h00);
    wt(10);
    chk_b(stby, 1'b1);
    rd(ar(fa));
    chk_d(rv, d);
    rd(ar(fa + 16'h0020));
    chk_d(rv, 8'hff);
  endtask : prog
  task erase(input logic [7:0] sel, input logic [15:0] fa, input int t, input int h);
    arm(sel, fa);
    // engine still busy, sequence in high voltage state
    rd(fpec_pkg::REG_STAT);
    chk_d(rv, 8'h42);
    chk_b(ahv, 1'b1);
    wt(t);
    wr(fpec_pkg::REG_CTRL, 8'h08);
    wt(h);
    wr(fpec_pkg::REG_CTRL, 8'h00);
    wt(10);
  endtask : erase
  task refused(input logic [7:0] c);
    rd(fpec_pkg::REG_CTRL);
    chk_d(rv, c);
    rd(fpec_pkg::REG_STAT);
    chk_b(rv[fpec_pkg::ST_REFUSED_BIT], 1'b1);
    chk_b(pump, 1'b0);
    chk_b(ahv, 1'b0);
    wr(fpec_pkg::REG_CTRL, 8'h00);
    wr(fpec_pkg::REG_STAT, 8'h01);
  endtask : refused

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    rstn = 1'b0;
    tv = 1'b0;
    halt = 1'b0;
    n_fail = 0;
    n_tests = 0;
    wt(16);
    rstn <= 1'b1;
    rd(fpec_pkg::REG_CTRL);
    chk_d(rv, fpec_pkg::CTRL_RST);
    rd(fpec_pkg::REG_STAT);
    chk_d(rv, 8'h00);
    chk_b(stby, 1'b1);
    chk_b(ahv, 1'b0);
    wr(19'h00008, 8'hff);
    chk_b(er, 1'b1);
    rd(ar(16'hed00));
    chk_b(er, 1'b1);
    wr(fpec_pkg::REG_CTRL, 8'h03);
    rd(fpec_pkg::REG_CTRL);
    chk_d(rv, 8'h00);
    wr(fpec_pkg::REG_CTRL, 8'h01);
    wr(fpec_pkg::REG_CTRL, 8'h03);
    rd(fpec_pkg::REG_CTRL);
    chk_d(rv, 8'h01);
    wr(fpec_pkg::REG_CTRL, 8'h06);
    rd(fpec_pkg::REG_CTRL);
    chk_d(rv, 8'h06);
    wr(fpec_pkg::REG_CTRL, 8'h09);
    refused(8'h01);
    prog(16'hee3f, 8'h0f);
    prog(16'hee40, 8'h33);
    prog(16'hffc0, 8'h12);
    erase(8'h02, 16'hee10, 10000, 50);
    rd(ar(16'hee3f));
    chk_d(rv, 8'hff);
    rd(ar(16'hee40));
    chk_d(rv, 8'h33);
    prog(16'hffbe, 8'hfe);
    arm(8'h01, 16'hff90);
    refused(8'h01);
    arm(8'h06, 16'hee00);
    refused(8'h06);
    tv <= 1'b1;
    erase(8'h06, 16'hee00, 40000, 1000);
    tv <= 1'b0;
    rd(ar(16'hffbe));
    chk_d(rv, 8'hff);
    rd(ar(16'hffc0));
    chk_d(rv, 8'hff);
    rd(ar(16'hee40));
    chk_d(rv, 8'hff);
    arm(8'h01, 16'hee80);
    wt(2);
    chk_b(pump, 1'b1);
    halt <= 1'b1;
    wt(1);
    halt <= 1'b0;
    wt(2);
    chk_b(stby, 1'b1);
    rd(fpec_pkg::REG_CTRL);
    chk_d(rv, 8'h00);
    finish_test();
  end
endmodule : fpec_top_tb
